// [core/scsc_ctrl.sv]
/*
 * system clock select controller: apb registers, source selection with
 * glitch free switch, internal oscillator postscaler, pll selection,
 * idle or sleep choice, status flags and a failure interrupt.
 * assumes: one 250 MHz clock; every oscillator input is a clock enable
 * style tick synchronous to it; configuration bits are stable.
 */
`timescale 1ns/1ps
`include "scsc_params.svh"

// Behaviour
// - source field 00 primary, 01 secondary, others internal block
// - any reset clears source field, primary becomes system clock
// - a write to the source field switches after a brief interval
// - frequency field 111..001 picks 16 MHz down to 250 kHz postscaler
// - field 000 gives 31.25 kHz from hf/512 or low-freq oscillator
// - watchdog always runs from the low-freq oscillator
// - frequency writes change internal output at once
// - reset sets internal output to 1 MHz
// - sleep request enters idle when bit 7 set, else sleep
// - bit 3 shows running on primary; reset value from two-speed bit
// - bit 2 reads 1 once hf oscillator is stable, 0 after reset
// - pll 3x or 4x picked by config or soft bits per mode
// - all other primary modes keep the pll off
// - four-bit config field picks one of six primary sources
// - rc, ext clock and internal modes choose pin io or fosc/4
// - primary clock failure forces the internal oscillator
module scsc_ctrl
    import scsc_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // configuration bits
    input  wire scsc_cfg_t   cfg,
    // oscillator ticks, hf running level and primary failure flag
    input  wire logic        primary_tick,
    input  wire logic        secondary_tick,
    input  wire logic        hf_tick,
    input  wire logic        lf_tick,
    input  wire logic        hf_running,
    input  wire logic        primary_failed,
    // core power request
    input  wire logic        sleep_req,
    // outputs
    output logic             sys_clk_en,
    output logic             wdt_clk_en,
    output logic             osc_output_pin_o,
    output logic             osc_output_pin_oe,
    output scsc_pll_t        pll_sel,
    output logic             idle_mode,
    output logic             sleep_mode,
    output logic             irq
);

    // registers
    logic [1:0] src_q, src_d;
    logic [2:0] freq_q;
    logic       idle_q;
    logic       lfsrc_q, spll_q, smul_q;
    logic [1:0] act_q;
    logic [1:0] swcnt_q;
    logic       switching_q;
    logic       startup_timeout_status_q, startup_timeout_status_init_q, started_q;
    logic [7:0] settle_q;
    logic       hfstab_q;
    logic [8:0] post_q;
    logic       ic_q;
    logic [1:0] ic_div_q;
    logic       sys_q, wdt_q, pin_q;
    logic [1:0] ist_q, ien_q;
    logic [31:0] rdata_q;
    logic       idle_mode_q, sleep_mode_q;
    logic       fail_q;

    // source code to choice
    function automatic scsc_src_t src_dec(input logic [1:0] code);
        if (code == 2'h0) begin
            return SCSC_SRC_PRIMARY;
        end else if (code == 2'h1) begin
            return SCSC_SRC_SECONDARY;
        end
        return SCSC_SRC_INTERNAL;
    endfunction : src_dec

    // bus decode
    wire acc      = psel & penable;
    wire wr       = acc & pwrite;
    wire hit_ctl  = paddr == `SCSC_OFF_OSC_CTRL;
    wire hit_ctl2 = paddr == `SCSC_OFF_OSC_CTRL2;
    wire hit_ist  = paddr == `SCSC_OFF_INT_STAT;
    wire hit_ien  = paddr == `SCSC_OFF_INT_EN;
    wire hit_icl  = paddr == `SCSC_OFF_INT_CLR;
    wire mapped   = hit_ctl | hit_ctl2 | hit_ist | hit_ien | hit_icl;
    wire wr_ctl   = wr & hit_ctl;
    wire wr_ctl2  = wr & hit_ctl2;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = rdata_q;

    // failure forces the internal block, software field untouched
    wire       fail_now  = primary_failed & (src_q == 2'h0);
    wire [1:0] want      = fail_q ? 2'h2 : src_q;
    wire       sw_req    = want != act_q;
    wire       sw_done   = switching_q & (swcnt_q == 2'h0);
    assign src_d = wr_ctl ? pwdata[`SCSC_BIT_SRC_HI:`SCSC_BIT_SRC_LO]
                          : src_q;

    // internal block postscaler, 31.25 kHz needs hf/512 or lf
    wire [3:0] post_log = (freq_q == 3'h0) ? `SCSC_DIV512_LOG
                                           : 4'(3'h7 - freq_q);
    wire [8:0] post_mask = 9'((10'h1 << post_log) - 10'h1);
    wire post_hit   = hf_tick & ((post_q & post_mask) == post_mask);
    wire lf_path    = (freq_q == 3'h0) & ~lfsrc_q;
    wire int_tick   = lf_path ? lf_tick : post_hit;

    // chosen source tick, gated off during transition
    wire cur_tick = (src_dec(act_q) == SCSC_SRC_PRIMARY)   ? primary_tick :
                    (src_dec(act_q) == SCSC_SRC_SECONDARY) ? secondary_tick
                                                           : int_tick;

    // pll selection per primary mode
    wire ec_hp   = cfg.primary_mode[3:1] == 3'h2;
    wire hs_hp   = cfg.primary_mode == 4'h2;
    assign pll_sel = (ec_hp & cfg.config_pll_enable) ?
                         (cfg.config_pll_mult_sel ? SCSC_PLL_X3 : SCSC_PLL_X4) :
                     (hs_hp & spll_q) ?
                         (smul_q ? SCSC_PLL_X3 : SCSC_PLL_X4) :
                     SCSC_PLL_OFF;

    // primary mode pin usage: odd rc/ec/internal_osc_mode codes drive fosc/4
    wire pin_capable = (cfg.primary_mode[3:1] == 3'h2) |
                       (cfg.primary_mode[3:1] == 3'h4) |
                       (cfg.primary_mode[3:1] == 3'h6);
    wire pin_clk     = pin_capable & cfg.primary_mode[0];

    // status read words
    wire [7:0] ctl_rd = {idle_q, freq_q, startup_timeout_status_q, hfstab_q, src_q};
    wire [7:0] ctl2_rd = {2'h0, lfsrc_q, spll_q, smul_q, 3'h0};

    // register writes and source selection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            src_q   <= `SCSC_RST_SRC;
            freq_q  <= `SCSC_RST_FREQ;
            idle_q  <= 1'b0;
            lfsrc_q <= 1'b0;
            spll_q  <= 1'b0;
            smul_q  <= 1'b0;
        end else begin
            src_q <= src_d;
            if (wr_ctl) begin
                freq_q <= pwdata[`SCSC_BIT_FREQ_HI:`SCSC_BIT_FREQ_LO];
                idle_q <= pwdata[`SCSC_BIT_IDLE];
            end
            if (wr_ctl2) begin
                lfsrc_q <= pwdata[`SCSC_BIT_LFSRC];
                spll_q  <= pwdata[`SCSC_BIT_SPLLEN];
                smul_q  <= pwdata[`SCSC_BIT_SPLLMUL];
            end
        end
    end

    // failure latch, cleared when software leaves the primary
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fail_q <= 1'b0;
        end else if (fail_now) begin
            fail_q <= 1'b1;
        end else if (src_q != 2'h0) begin
            fail_q <= 1'b0;
        end
    end

    // transition: hold the output low a short interval, then move over
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            act_q       <= `SCSC_RST_SRC;
            switching_q <= 1'b0;
            swcnt_q     <= 2'h0;
        end else if (sw_req & ~switching_q) begin
            switching_q <= 1'b1;
            swcnt_q     <= 2'(`SCSC_SWITCH_CYC - 1);
        end else if (sw_done) begin
            switching_q <= 1'b0;
            act_q       <= want;
        end else if (switching_q) begin
            swcnt_q <= swcnt_q - 2'h1;
        end
    end

    // postscaler counter on the hf oscillator
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            post_q <= 9'h0;
        end else if (hf_tick) begin
            post_q <= post_q + 9'h1;
        end
    end

    // clock enables from flops; no system enable issued mid switch, watchdog enable still runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_q <= 1'b0;
            wdt_q <= 1'b0;
        end else begin
            sys_q <= cur_tick & ~switching_q & ~sw_req;
            wdt_q <= lf_tick;
        end
    end
    assign sys_clk_en = sys_q;
    assign wdt_clk_en = wdt_q;

    // fosc/4 on the oscillator output pin
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ic_div_q <= 2'h0;
            ic_q     <= 1'b0;
            pin_q    <= 1'b0;
        end else begin
            if (sys_q) begin
                ic_div_q <= ic_div_q + 2'h1;
            end
            ic_q  <= sys_q & (ic_div_q == 2'h3);
            pin_q <= ic_q;
        end
    end
    assign osc_output_pin_o  = pin_q;
    assign osc_output_pin_oe = pin_clk;

    // start-up status, reset value taken after release from the strap
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            started_q   <= 1'b0;
            startup_timeout_status_init_q <= 1'b0;
            startup_timeout_status_q      <= 1'b0;
        end else begin
            started_q <= 1'b1;
            if (!started_q) begin
                startup_timeout_status_init_q <= ~cfg.two_speed_startup_cfg;
                startup_timeout_status_q      <= ~cfg.two_speed_startup_cfg;
            end else begin
                startup_timeout_status_q <= (act_q == 2'h0) & ~switching_q;
            end
        end
    end

    // hf stability after a settle count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            settle_q <= 8'h0;
            hfstab_q <= 1'b0;
        end else if (!hf_running) begin
            settle_q <= 8'h0;
            hfstab_q <= 1'b0;
        end else if (settle_q == `SCSC_HF_SETTLE) begin
            hfstab_q <= 1'b1;
        end else begin
            settle_q <= settle_q + 8'h1;
        end
    end

    // power mode on a sleep request
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_mode_q  <= 1'b0;
            sleep_mode_q <= 1'b0;
        end else if (sleep_req) begin
            idle_mode_q  <= idle_q;
            sleep_mode_q <= ~idle_q;
        end else begin
            idle_mode_q  <= 1'b0;
            sleep_mode_q <= 1'b0;
        end
    end
    assign idle_mode  = idle_mode_q;
    assign sleep_mode = sleep_mode_q;

    // interrupts: bit0 failure, bit1 switch done; set wins over clear
    wire [1:0] ev  = {sw_done, fail_now & ~fail_q};
    wire [1:0] clr = (wr & hit_icl) ? pwdata[1:0] : 2'h0;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ist_q <= 2'h0;
            ien_q <= 2'h0;
        end else begin
            ist_q <= (ist_q & ~clr) | ev;
            if (wr & hit_ien) begin
                ien_q <= pwdata[1:0];
            end
        end
    end
    assign irq = |(ist_q & ien_q);

    // read data, registered at the setup cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (psel & ~penable) begin
            rdata_q <= hit_ctl  ? {24'h0, ctl_rd}  :
                       hit_ctl2 ? {24'h0, ctl2_rd} :
                       hit_ist  ? {30'h0, ist_q}   :
                       hit_ien  ? {30'h0, ien_q}   : 32'h0;
        end
    end

endmodule : scsc_ctrl

// [include/scsc_params.svh]
/*
 * offsets, field positions, reset values and timing counts of the
 * clock select controller.
 * assumes: included by bare name, after nothing else.
 */
`ifndef SCSC_PARAMS_SVH
`define SCSC_PARAMS_SVH

// register byte offsets
`define SCSC_OFF_OSC_CTRL   12'h000
`define SCSC_OFF_OSC_CTRL2  12'h004
`define SCSC_OFF_INT_STAT   12'h008
`define SCSC_OFF_INT_EN     12'h00c
`define SCSC_OFF_INT_CLR    12'h010

// oscillator_control field positions
`define SCSC_BIT_IDLE       7
`define SCSC_BIT_FREQ_HI    6
`define SCSC_BIT_FREQ_LO    4
`define SCSC_BIT_STARTUP_TIMEOUT_STATUS       3
`define SCSC_BIT_HFSTABLE   2
`define SCSC_BIT_SRC_HI     1
`define SCSC_BIT_SRC_LO     0

// second control register positions
`define SCSC_BIT_LFSRC      5
`define SCSC_BIT_SPLLEN     4
`define SCSC_BIT_SPLLMUL    3

// reset values
`define SCSC_RST_FREQ       3'h3
`define SCSC_RST_SRC        2'h0

// clock switch transition interval, ns, and cycles at 4 ns
`define SCSC_SWITCH_NS      16
`define SCSC_CLK_NS         4
`define SCSC_SWITCH_CYC     ((`SCSC_SWITCH_NS + `SCSC_CLK_NS - 1) / `SCSC_CLK_NS)

// hf oscillator settle, cycles of the bus clock
`define SCSC_HF_SETTLE      8'h10

// postscaler divide ratios, log2
`define SCSC_DIV512_LOG     4'h9
`endif

// [include/scsc_pkg.sv]
/*
 * types of the clock select controller.
 * assumes: compiled before the core.
 */
package scsc_pkg;
    typedef enum logic [1:0] {
        SCSC_SRC_PRIMARY,
        SCSC_SRC_SECONDARY,
        SCSC_SRC_INTERNAL
    } scsc_src_t;

    typedef enum logic [1:0] {
        SCSC_PLL_OFF,
        SCSC_PLL_X3,
        SCSC_PLL_X4
    } scsc_pll_t;

    typedef struct packed {
        logic       config_pll_enable;
        logic       config_pll_mult_sel;
        logic [3:0] primary_mode;
        logic       two_speed_startup_cfg;
    } scsc_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } scsc_apb_req_t;
endpackage : scsc_pkg

// [tb/scsc_ctrl_sva.sv]
/* port checker of the clock select controller.
   assumes: bound to scsc_ctrl from the bench top, one clock domain. */
`timescale 1ns/1ps
module scsc_ctrl_sva
    import scsc_pkg::*;
(
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // configuration and causes
    input wire scsc_cfg_t   cfg,
    input wire logic        lf_tick,
    input wire logic        sleep_req,
    // watched outputs
    input wire logic        wdt_clk_en,
    input wire logic        osc_output_pin_oe,
    input wire scsc_pll_t   pll_sel,
    input wire logic        idle_mode,
    input wire logic        sleep_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // decode of access, map and pll capable modes
    wire       acc = psel && penable;
    wire       mapped = paddr inside {12'h000, 12'h004, 12'h008,
                                      12'h00c, 12'h010};
    wire [3:0] md = cfg.primary_mode;
    wire       ec_pll = md[3:1] == 3'h2 && cfg.config_pll_enable;
    wire       pin_md = md inside {4'h5, 4'h9, 4'hd};
    sequence s_sleep_held;
        sleep_req ##1 sleep_req;
    endsequence
    property p_wdt_on;  lf_tick |=> wdt_clk_en; endproperty
    property p_wdt_off; !lf_tick |=> !wdt_clk_en; endproperty
    property p_power;   s_sleep_held |-> idle_mode != sleep_mode; endproperty
    property p_run;     !sleep_req |=> !idle_mode && !sleep_mode; endproperty
    property p_pll_ec;
        ec_pll |-> pll_sel == (cfg.config_pll_mult_sel ? SCSC_PLL_X3
                                                        : SCSC_PLL_X4);
    endproperty
    property p_pll_off;
        !ec_pll && md != 4'h2 |-> pll_sel == SCSC_PLL_OFF;
    endproperty
    property p_pin;     osc_output_pin_oe == pin_md; endproperty
    property p_rdy;     acc |-> pready; endproperty
    property p_err;     acc && !mapped |-> pslverr; endproperty
    property p_ok;      acc && mapped |-> !pslverr; endproperty
    a_wdt_on:  assert property (p_wdt_on)
        else $error("wdt tick lost");
    a_wdt_off: assert property (p_wdt_off)
        else $error("wdt extra");
    a_power:   assert property (p_power)
        else $error("power mode");
    a_run:     assert property (p_run)
        else $error("mode not run");
    a_pll_ec:  assert property (p_pll_ec)
        else $error("pll ext");
    a_pll_off: assert property (p_pll_off)
        else $error("pll on");
    a_pin:     assert property (p_pin)
        else $error("pin enable");
    a_rdy:     assert property (p_rdy) else $error("no ready");
    a_err:     assert property (p_err) else $error("no slverr");
    a_ok:      assert property (p_ok) else $error("bad slverr");
endmodule : scsc_ctrl_sva

// [tb/tb_scsc_ctrl.sv]
/* self-checking bench of the clock select controller.
   assumes: design and checker compiled first; apb master in here. */
`timescale 1ns/1ps
module tb_scsc_ctrl
    import scsc_pkg::*;
;
    logic        clock, rst, psel, penable, pwrite, sleep_req;
    logic        primary_tick, secondary_tick, hf_tick, lf_tick;
    logic        hf_running, primary_failed, pready, pslverr, irq;
    logic        sys_clk_en, wdt_clk_en, pin_o, pin_oe;
    logic        idle_mode, sleep_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] seed;
    scsc_pll_t   pll_sel;
    scsc_cfg_t   cfg;
    int          error_cnt, tests_run, cyc, hf_per, lf_per, pri_per;
    int          sec_per, c, pc, e;

    scsc_ctrl u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cfg, .primary_tick,
        .secondary_tick, .hf_tick, .lf_tick, .hf_running, .primary_failed,
        .sleep_req, .sys_clk_en, .wdt_clk_en, .osc_output_pin_o(pin_o),
        .osc_output_pin_oe(pin_oe), .pll_sel, .idle_mode, .sleep_mode,
        .irq);

    // 250 MHz clock
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    // oscillator ticks at bench chosen periods, zero period is stopped
    always @(posedge clock) begin
        cyc <= cyc + 1;
        hf_tick <= hf_per != 0 && cyc % hf_per == 0;
        lf_tick <= lf_per != 0 && cyc % lf_per == 0;
        primary_tick <= pri_per != 0 && cyc % pri_per == 0;
        secondary_tick <= sec_per != 0 && cyc % sec_per == 0;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] near(input int a, input int e);
        return {31'h0, a >= e - 1 && a <= e + 1};
    endfunction : near
    function automatic scsc_pll_t exp_pll(input logic [3:0] m,
        input logic ce, input logic cm, input logic se, input logic sm);
        if (m[3:1] == 3'h2 && ce) return cm ? SCSC_PLL_X3 : SCSC_PLL_X4;
        if (m == 4'h2 && se) return sm ? SCSC_PLL_X3 : SCSC_PLL_X4;
        return SCSC_PLL_OFF;
    endfunction : exp_pll

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // one apb transfer, read data lands in rd
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        for (n = 0; n < 16; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            test_done;
        end
        rd = prdata;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // system ticks and pin pulses over n cycles after the switch settles,
    // sampled mid cycle so that the flop outputs have settled
    task automatic cnt(input int n, output int k);
        repeat (8) @(posedge clock);
        k = 0;
        pc = 0;
        repeat (n) begin
            @(negedge clock);
            k += (sys_clk_en === 1'b1);
            pc += (pin_o === 1'b1);
        end
    endtask : cnt

    // main sequence
    initial begin
        {psel, penable, pwrite, sleep_req, hf_running} = 0;
        {primary_failed, paddr, pwdata, cyc, hf_per, lf_per} = 0;
        {pri_per, sec_per, error_cnt, tests_run} = 0;
        cfg = '0;
        seed = 16'ha22f;
        rst = 1;
        repeat (6) @(posedge clock);
        rst <= 0;
        apb(0, 12'h000, 0);
        chk("ctrl_reset", 32'h38, rd);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            apb(1, 12'h000, {24'h0, seed[7:4], 4'h0});
            apb(0, 12'h000, 0);
            chk("ctrl_rw", {24'h0, seed[7:4], 4'h0}, rd & 32'hf3);
            apb(1, 12'h004, {16'h0, seed});
            apb(0, 12'h004, 0);
            chk("ctrl2_rw", {24'h0, seed[7:0]} & 32'h38, rd & 32'h38);
        end
        apb(1, 12'h014, 32'hffffffff);
        apb(0, 12'h014, 0);
        chk("unmapped", 0, rd);
        $display("test registers done");
        hf_running <= 1; hf_per <= 1; lf_per <= 8; pri_per <= 2;
        sec_per <= 4;
        apb(1, 12'h004, 0);
        repeat (20) @(posedge clock);
        apb(0, 12'h000, 0);
        chk("hf_stable", 1, rd[2]);
        for (int f = 0; f < 8; f++) begin
            apb(1, 12'h000, {25'h0, f[2:0], 4'h2});
            cnt(256, c);
            chk("postscale", 1, near(c, f == 0 ? 32 : 256 >> (7 - f)));
        end
        apb(1, 12'h000, 32'h02);
        apb(1, 12'h004, 32'h20);
        cnt(1024, c);
        chk("hf_div512", 1, near(c, 2));
        for (int s = 0; s < 4; s++) begin
            apb(1, 12'h000, {24'h0, 8'h70 | s[7:0]});
            cnt(256, c);
            e = s == 0 ? 128 : s == 1 ? 64 : 256;
            chk("source", 1, near(c, e));
            chk("pin_clk", 1, near(pc, e / 4));
            apb(0, 12'h000, 0);
            chk("startup_timeout_status", s == 0, rd[3]);
        end
        $display("test clocks done");
        apb(1, 12'h000, 32'h30);
        apb(1, 12'h010, 32'h3);
        primary_failed <= 1;
        cnt(256, c);
        primary_failed <= 0;
        chk("fail_internal", 1, near(c, 16));
        apb(0, 12'h008, 0);
        #1 chk("stat_fail", 1, rd[0]);
        chk("irq_masked", 0, irq);
        apb(1, 12'h00c, 1);
        #1 chk("irq_on", 1, irq);
        apb(1, 12'h00c, 0);
        #1 chk("irq_off", 0, irq);
        apb(1, 12'h00c, 1);
        apb(1, 12'h010, 1);
        #1 chk("irq_clear", 0, irq);
        apb(1, 12'h000, 32'hb0);
        sleep_req <= 1;
        repeat (3) @(posedge clock);
        #1 chk("idle", 1, idle_mode);
        apb(1, 12'h000, 32'h30);
        repeat (2) @(posedge clock);
        #1 chk("sleep", 1, sleep_mode);
        sleep_req <= 0;
        $display("test events done");
        for (int m = 0; m < 64; m++) begin
            seed = lfsr(seed);
            cfg <= '{seed[0], seed[1], m[3:0], 1'b0};
            apb(1, 12'h004, {27'h0, seed[2], seed[3], 3'h0});
            #1 chk("pll", exp_pll(m[3:0], seed[0], seed[1], seed[2], seed[3]), pll_sel);
            chk("pin_oe", {31'h0, m[3:0] inside {5, 9, 13}}, pin_oe);
        end
        apb(1, 12'h000, 32'hf1);
        cfg.two_speed_startup_cfg <= 1'b1;
        rst <= 1;
        repeat (2) @(posedge clock);
        rst <= 0;
        apb(0, 12'h000, 0);
        chk("ctrl_rerst", 32'h30, rd);
        $display("test modes done");
        test_done;
    end
endmodule : tb_scsc_ctrl

bind scsc_ctrl scsc_ctrl_sva u_sva (.clock, .rst, .psel, .penable, .paddr,
    .pready, .pslverr, .cfg, .lf_tick, .sleep_req, .wdt_clk_en,
    .osc_output_pin_oe, .pll_sel, .idle_mode, .sleep_mode);
